// ### bench/ccss_ctrl_model.sv
// Purpose: Remote controller model that takes answer bytes from the block.
// Assumes: One answer at a time, each ending with a newline byte.
// Notes:   Slow mode stalls every other cycle to stretch each answer.
`include "ccss_defs.svh"
module ccss_ctrl_model
(
    // Clock
    input  wire logic                   clk,
    // Answer stream
    input  wire logic                   rsp_valid,
    input  wire ccss_pkg::ccss_rsp_type rsp_q,
    output logic                        rsp_ready,
    // Pacing
    input  wire logic                   slow
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] text[$];      // Bytes of the answers gathered so far
    int         lines = 0;    // Count of whole answers taken
    logic       phase_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Take a byte only at an edge where ready was high; ready moves just
    // after the edge so the block never sees it change under its sample
    always @(posedge clk)
    begin
        if (rsp_valid && rsp_ready)
        begin
            text.push_back(rsp_q.data);
            if (rsp_q.last) lines++;
        end
        phase_q <= #1 ~phase_q;
    end
    assign rsp_ready = ~slow | phase_q;
endmodule : ccss_ctrl_model

// ### bench/ccss_top_tb.sv
// Purpose: Self-checking bench for the common command and status block.
// Assumes: Self-test shortened to 20 cycles.
// Notes:   Commands go through send; answers are gathered by the model.
`include "ccss_defs.svh"
module ccss_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic CLK = 1'b0, RESETN, CMD_VALID, CMD_READY, RSP_VALID, RSP_READY, SPOLL, SRQ;
    logic SETUP_LOAD_Q, DEFAULT_LOAD_Q, SINGLE_MODE, TRIG_MET, ACQ_START_Q;
    logic TEST_START_Q, ERR_SHOW_Q, POWER_ON_EVENT_Q, SLOW;
    ccss_pkg::ccss_cmd_type  CMD;
    ccss_pkg::ccss_rsp_type  RSP_Q;
    ccss_pkg::ccss_cond_type COND;
    logic [7:0]  POLL_BYTE_Q, TEST_RESULT;
    logic [31:0] SETUP_IN, SETUP_Q, seen_setup;
    logic [6:0]  COMPLETE_Q;
    int num_errors = 0, checked = 0, cycles = 0;
    int n_load, n_err, n_acq, n_dflt, n_test;

    ccss_top #(.TST_CYCLES(20)) dut_u
    (
        .CLK(CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
        .CMD(CMD), .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP_Q(RSP_Q),
        .COND(COND), .SPOLL(SPOLL), .POLL_BYTE_Q(POLL_BYTE_Q), .SRQ(SRQ),
        .SETUP_IN(SETUP_IN), .SETUP_Q(SETUP_Q), .SETUP_LOAD_Q(SETUP_LOAD_Q),
        .COMPLETE_Q(COMPLETE_Q), .DEFAULT_LOAD_Q(DEFAULT_LOAD_Q),
        .SINGLE_MODE(SINGLE_MODE), .TRIG_MET(TRIG_MET), .ACQ_START_Q(ACQ_START_Q),
        .TEST_START_Q(TEST_START_Q), .TEST_RESULT(TEST_RESULT),
        .ERR_SHOW_Q(ERR_SHOW_Q), .POWER_ON_EVENT_Q(POWER_ON_EVENT_Q)
    );
    ccss_ctrl_model ctrl_u
    (
        .clk(CLK), .rsp_valid(RSP_VALID), .rsp_q(RSP_Q), .rsp_ready(RSP_READY),
        .slow(SLOW)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and pulse counters
    always #2.5 CLK = ~CLK;
    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            num_errors++;
            stop_test();
        end
        if (SETUP_LOAD_Q === 1'b1) seen_setup = SETUP_Q;
        n_load += int'(SETUP_LOAD_Q === 1'b1);
        n_err  += int'(ERR_SHOW_Q === 1'b1);
        n_acq  += int'(ACQ_START_Q === 1'b1);
        n_dflt += int'(DEFAULT_LOAD_Q === 1'b1);
        n_test += int'(TEST_START_Q === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : check

    // Offer one command mid-cycle and hold it until the edge that takes it
    task automatic send(input logic [3:0] code, input logic [7:0] arg);
        int i;
        @(posedge CLK);
        #1;
        CMD_VALID = 1'b1;
        CMD       = '{code: code, arg: arg};
        for (i = 0; i < 50 && CMD_READY !== 1'b1; i++) @(posedge CLK) #1;
        @(posedge CLK);
        #1 CMD_VALID = 1'b0;
        n_load = 0;
        n_err  = 0;
        n_acq  = 0;
        n_dflt = 0;
        n_test = 0;
    endtask : send

    // Issue a query and compare the whole answer, newline included
    task automatic query(input logic [3:0] code, input string s);
        logic [31:0] exp, got;
        int          n;
        exp = 32'h0;
        got = 32'h0;
        n   = ctrl_u.lines;
        ctrl_u.text.delete();
        send(code, 8'h00);
        for (int i = 0; i < 200 && ctrl_u.lines == n; i++) @(posedge CLK);
        #1;
        foreach (s[i]) exp = {exp[23:0], s[i]};
        exp = {exp[23:0], `CCSS_NL};
        foreach (ctrl_u.text[i]) got = {got[23:0], ctrl_u.text[i]};
        check("answer", exp, got);
    endtask : query

    // Load a mask, set the conditions, read the status byte and the request
    task automatic stb(input logic [7:0] m, input logic [5:0] c, input string s, input logic r);
        send(`CCSS_CMD_SRE_SET, m);
        COND = c;
        query(`CCSS_CMD_STB_QRY, s);
        check("srq", 32'(r), 32'(SRQ));
    endtask : stb

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {CMD_VALID, SPOLL, SINGLE_MODE, TRIG_MET, SLOW, RESETN} = 6'h00;
        CMD = '0;
        COND = '0;
        SETUP_IN = 32'h0;
        TEST_RESULT = 8'h00;
        repeat (12) @(posedge CLK);
        #1 RESETN = 1'b1;
        @(posedge CLK) #1;
        check("pon", 32'h1, 32'(POWER_ON_EVENT_Q));
        check("complete", 32'd90, 32'(COMPLETE_Q));
        query(`CCSS_CMD_PSC_QRY, "0");
        send(`CCSS_CMD_PSC_SET, 8'h01);
        query(`CCSS_CMD_PSC_QRY, "1");
        send(`CCSS_CMD_SRE_SET, 8'h20);
        query(`CCSS_CMD_SRE_QRY, "32");
        SLOW = 1'b1;
        send(`CCSS_CMD_SRE_SET, 8'hff);
        query(`CCSS_CMD_SRE_QRY, "183");
        SLOW = 1'b0;
        stb(8'h00, 6'h21, "129", 1'b0);
        stb(8'h01, 6'h21, "193", 1'b1);
        stb(8'h02, 6'h21, "129", 1'b0);
        stb(8'h02, 6'h3f, "247", 1'b1);
        #1 SPOLL = 1'b1;
        @(posedge CLK) #1 SPOLL = 1'b0;
        @(posedge CLK) #1;
        check("poll", 32'hf7, 32'(POLL_BYTE_Q));
        COND = '0;
        SETUP_IN = 32'h1234abcd;
        send(`CCSS_CMD_SAV, `CCSS_SLOT_MAX);
        // Hold the setup through the edge that ends the execute cycle
        @(posedge CLK) #1;
        SETUP_IN = 32'h0;
        send(`CCSS_CMD_RCL, `CCSS_SLOT_MAX);
        repeat (6) @(posedge CLK);
        check("load", 32'h1, 32'(n_load));
        check("setup", 32'h1234abcd, seen_setup);
        send(`CCSS_CMD_RCL, 8'h00);
        repeat (6) @(posedge CLK);
        check("empty", 32'h1, 32'(n_err));
        check("kept", 32'h0, 32'(n_load));
        send(`CCSS_CMD_RST, 8'h00);
        repeat (4) @(posedge CLK) #1;
        check("default", 32'h1, 32'(n_dflt));
        check("complete", 32'd90, 32'(COMPLETE_Q));
        send(`CCSS_CMD_TRG, 8'h00);
        repeat (6) @(posedge CLK);
        check("acq", 32'h1, 32'(n_acq));
        SINGLE_MODE = 1'b1;
        send(`CCSS_CMD_TRG, 8'h00);
        repeat (20) @(posedge CLK);
        check("early", 32'h0, 32'(n_acq));
        #1 TRIG_MET = 1'b1;
        repeat (8) @(posedge CLK);
        check("single", 32'h1, 32'(n_acq));
        TEST_RESULT = 8'h05;
        query(`CCSS_CMD_TST_QRY, "5");
        check("test", 32'h1, 32'(n_test));
        TEST_RESULT = 8'h00;
        query(`CCSS_CMD_TST_QRY, "0");
        stop_test();
    end
endmodule : ccss_top_tb

// ### logic/ccss_dec.sv
// Purpose: Decimal formatting of a byte for query answers.
// Assumes: Value 0 to 255.
// Notes:   Combinational; leading zeros suppressed.
module ccss_dec
(
    // Value and digits
    input  wire logic [7:0] value,
    output logic      [7:0] d2,
    output logic      [7:0] d1,
    output logic      [7:0] d0,
    output logic      [1:0] ndig
);
    logic [7:0] h;
    logic [7:0] t;

    // Split into hundreds, tens and units
    always_comb
    begin
        h    = value / 8'h64;
        t    = (value % 8'h64) / 8'h0a;
        d2   = 8'h30 + h;
        d1   = 8'h30 + t;
        d0   = 8'h30 + (value % 8'h0a);
        ndig = (h != 8'h00) ? 2'h3 : (t != 8'h00) ? 2'h2 : 2'h1;
    end
endmodule : ccss_dec

// ### logic/ccss_defs.svh
// Purpose: Constants of the common command and status service block.
// Assumes: Clock of 200 MHz.
// Notes:   Positions, codes and counts as macros.
`ifndef CCSS_DEFS_SVH
`define CCSS_DEFS_SVH

// Status byte and mask bit positions
`define CCSS_BIT_TRIG      0
`define CCSS_BIT_USER      1
`define CCSS_BIT_MSG       2
`define CCSS_BIT_UNUSED3   3
`define CCSS_BIT_MAV       4
`define CCSS_BIT_ESB       5
`define CCSS_BIT_SUMMARY   6
`define CCSS_BIT_STATUS_GROUP_SUMMARY      7
// Mask bits that may be stored; 6 and 3 unused
`define CCSS_MASK_USED     8'hb7

// Command codes
`define CCSS_CMD_PSC_SET   4'h1
`define CCSS_CMD_PSC_QRY   4'h2
`define CCSS_CMD_RCL       4'h3
`define CCSS_CMD_RST       4'h4
`define CCSS_CMD_SAV       4'h5
`define CCSS_CMD_SRE_SET   4'h6
`define CCSS_CMD_SRE_QRY   4'h7
`define CCSS_CMD_STB_QRY   4'h8
`define CCSS_CMD_TRG       4'h9
`define CCSS_CMD_TST_QRY   4'ha

// Slots and setup
`define CCSS_SLOTS         10
`define CCSS_SLOT_MAX      4'h9
`define CCSS_SETUP_W       32
// Default completion criterion, percent
`define CCSS_COMPLETE_DEF  7'h5a
// Newline terminator
`define CCSS_NL            8'h0a

// Self-test duration, minutes, and its cycle count at 200 MHz
`define CCSS_TST_MINUTES   10
`define CCSS_CLK_MHZ       200
`define CCSS_TST_CYCLES    (64'(`CCSS_TST_MINUTES) * 64'd60 * 64'd1000000 * 64'(`CCSS_CLK_MHZ))

`endif

// ### logic/ccss_pkg.sv
// Purpose: Types of the common command and status service block.
// Assumes: Used with ccss_defs.svh.
// Notes:   Commands and answers travel as packed structs.
package ccss_pkg;

    // One command from the message parser
    typedef struct packed {
        logic [3:0] code;
        logic [7:0] arg;
    } ccss_cmd_type;

    // One answer byte toward the output queue
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } ccss_rsp_type;

    // Condition inputs feeding the status byte
    typedef struct packed {
        logic status_group_summary;
        logic esb;
        logic mav;
        logic message_shown_flag;
        logic user;
        logic trig;
    } ccss_cond_type;

    typedef enum logic [5:0] {
        CCSS_IDLE = 6'h01,
        CCSS_EXEC = 6'h02,
        CCSS_SEND = 6'h04,
        CCSS_TEST = 6'h08,
        CCSS_MEMR = 6'h10,
        CCSS_ARM  = 6'h20
    } ccss_state_type;

endpackage : ccss_pkg

// ### logic/ccss_slot_mem.sv
// Purpose: Ten setup slots with valid flags.
// Assumes: One write or read per cycle.
// Notes:   Read data is registered, one cycle after the request.
`include "ccss_defs.svh"
module ccss_slot_mem
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // Access
    input  wire logic                     wr_en,
    input  wire logic [3:0]               addr,
    input  wire logic [`CCSS_SETUP_W-1:0] wr_data,
    output logic      [`CCSS_SETUP_W-1:0] rd_data_q,
    output logic                          rd_valid_q
);
    logic [`CCSS_SETUP_W-1:0] mem [`CCSS_SLOTS];
    logic [`CCSS_SLOTS-1:0]   full_q;

    // Storage writes; contents are undefined until written
    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[addr] <= wr_data;
        rd_data_q <= mem[addr];
    end

    // Slot-written flags clear only at reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            full_q     <= '0;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            if (wr_en)
                full_q[addr] <= 1'b1;
            rd_valid_q <= full_q[addr];
        end
    end
endmodule : ccss_slot_mem

// ### logic/ccss_top.sv
// Purpose: Common command interpreter with status byte and service request.
// Assumes: Parser hands one decoded command at a time on CMD.
// Notes:   Answers leave as ASCII bytes ending with newline.
`include "ccss_defs.svh"
module ccss_top
#(
    parameter longint TST_CYCLES = `CCSS_TST_CYCLES
)
(
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RESETN,
    // Commands
    input  wire logic                     CMD_VALID,
    output logic                          CMD_READY,
    input  wire ccss_pkg::ccss_cmd_type   CMD,
    // Answers
    output logic                          RSP_VALID,
    input  wire logic                     RSP_READY,
    output ccss_pkg::ccss_rsp_type        RSP_Q,
    // Status conditions and serial poll
    input  wire ccss_pkg::ccss_cond_type  COND,
    input  wire logic                     SPOLL,
    output logic [7:0]                    POLL_BYTE_Q,
    output logic                          SRQ,
    // Setup, acquisition and test
    input  wire logic [`CCSS_SETUP_W-1:0] SETUP_IN,
    output logic [`CCSS_SETUP_W-1:0]      SETUP_Q,
    output logic                          SETUP_LOAD_Q,
    output logic [6:0]                    COMPLETE_Q,
    output logic                          DEFAULT_LOAD_Q,
    input  wire logic                     SINGLE_MODE,
    input  wire logic                     TRIG_MET,
    output logic                          ACQ_START_Q,
    output logic                          TEST_START_Q,
    input  wire logic [7:0]               TEST_RESULT,
    output logic                          ERR_SHOW_Q,
    output logic                          POWER_ON_EVENT_Q
);
    ccss_pkg::ccss_state_type state_q;
    ccss_pkg::ccss_cmd_type   cmd_q;
    logic        psc_flag_q;
    logic        boot_q;
    logic [7:0]  mask_q;
    logic [7:0]  stb;
    logic        mss;
    logic [7:0]  value_q;
    logic [1:0]  idx_q;
    logic [1:0]  ndig;
    logic [7:0]  d2;
    logic [7:0]  d1;
    logic [7:0]  d0;
    logic [63:0] tst_cnt_q;
    logic [`CCSS_SETUP_W-1:0] mem_rd;
    logic        mem_ok;
    logic        mem_wr;
    logic        rqs_q;
    logic        trig_sync1_q;
    logic        trig_sync2_q;
    logic        slot_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Status byte and summary

    // Bit 3 is hard zero; bit 6 replaced by summary
    always_comb
    begin
        stb = 8'h00;
        stb[`CCSS_BIT_TRIG] = COND.trig;
        stb[`CCSS_BIT_USER] = COND.user;
        stb[`CCSS_BIT_MSG]  = COND.message_shown_flag;
        stb[`CCSS_BIT_MAV]  = COND.mav;
        stb[`CCSS_BIT_ESB]  = COND.esb;
        stb[`CCSS_BIT_STATUS_GROUP_SUMMARY] = COND.status_group_summary;
        mss = |(stb & mask_q & ~(8'h01 << `CCSS_BIT_SUMMARY));
        stb[`CCSS_BIT_SUMMARY] = mss;
    end

    assign SRQ = mss;

    // Request service sets while the summary is high and SPOLL is low, clears when polled or when the summary falls
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            rqs_q <= 1'b0;
        else if (mss && !rqs_q && !SPOLL)
            rqs_q <= 1'b1;
        else if (SPOLL || !mss)
            rqs_q <= mss && !SPOLL ? rqs_q : 1'b0;
    end

    // Poll byte carries request service ORed with the summary at bit 6
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            POLL_BYTE_Q <= 8'h00;
        else if (SPOLL)
            POLL_BYTE_Q <= {stb[7], rqs_q | mss, stb[5:0]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger condition synchroniser, pin from acquisition front end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            trig_sync1_q <= 1'b0;
            trig_sync2_q <= 1'b0;
        end
        else
        begin
            trig_sync1_q <= TRIG_MET;
            trig_sync2_q <= trig_sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    ccss_dec u_dec
    (
        .value (value_q),
        .d2    (d2),
        .d1    (d1),
        .d0    (d0),
        .ndig  (ndig)
    );

    assign slot_ok = (cmd_q.arg[7:4] == 4'h0) && (cmd_q.arg[3:0] <= `CCSS_SLOT_MAX);
    assign mem_wr  = (state_q == ccss_pkg::CCSS_EXEC) && (cmd_q.code == `CCSS_CMD_SAV)
                     && slot_ok;

    ccss_slot_mem u_mem
    (
        .clk        (CLK),
        .resetn     (RESETN),
        .wr_en      (mem_wr),
        .addr       (cmd_q.arg[3:0]),
        .wr_data    (SETUP_IN),
        .rd_data_q  (mem_rd),
        .rd_valid_q (mem_ok)
    );

    assign CMD_READY = (state_q == ccss_pkg::CCSS_IDLE);
    assign RSP_VALID = (state_q == ccss_pkg::CCSS_SEND);

    // Answer byte: digits then newline
    always_comb
    begin
        RSP_Q.last = (idx_q == ndig);
        if (idx_q == ndig)
            RSP_Q.data = `CCSS_NL;
        else if (ndig - idx_q == 2'h3)
            RSP_Q.data = d2;
        else if (ndig - idx_q == 2'h2)
            RSP_Q.data = d1;
        else
            RSP_Q.data = d0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_q      <= ccss_pkg::CCSS_IDLE;
            cmd_q        <= '0;
            value_q      <= 8'h00;
            idx_q        <= 2'h0;
            tst_cnt_q    <= 64'h0;
            ACQ_START_Q  <= 1'b0;
            TEST_START_Q <= 1'b0;
        end
        else
        begin
            ACQ_START_Q  <= 1'b0;
            TEST_START_Q <= 1'b0;
            unique case (state_q)
                ccss_pkg::CCSS_IDLE:
                    if (CMD_VALID)
                    begin
                        cmd_q   <= CMD;
                        state_q <= ccss_pkg::CCSS_EXEC;
                    end
                ccss_pkg::CCSS_EXEC:
                begin
                    idx_q   <= 2'h0;
                    state_q <= ccss_pkg::CCSS_IDLE;
                    case (cmd_q.code)
                        `CCSS_CMD_PSC_QRY:
                        begin
                            value_q <= {7'h00, psc_flag_q};
                            state_q <= ccss_pkg::CCSS_SEND;
                        end
                        `CCSS_CMD_SRE_QRY:
                        begin
                            value_q <= mask_q;
                            state_q <= ccss_pkg::CCSS_SEND;
                        end
                        `CCSS_CMD_STB_QRY:
                        begin
                            value_q <= stb;
                            state_q <= ccss_pkg::CCSS_SEND;
                        end
                        `CCSS_CMD_RCL:
                            if (slot_ok)
                                state_q <= ccss_pkg::CCSS_MEMR;
                        `CCSS_CMD_TRG:
                            state_q <= ccss_pkg::CCSS_ARM;
                        `CCSS_CMD_TST_QRY:
                        begin
                            tst_cnt_q    <= 64'h0;
                            TEST_START_Q <= 1'b1;
                            state_q      <= ccss_pkg::CCSS_TEST;
                        end
                        default:
                            state_q <= ccss_pkg::CCSS_IDLE;
                    endcase
                end
                ccss_pkg::CCSS_MEMR:
                    state_q <= ccss_pkg::CCSS_IDLE;
                ccss_pkg::CCSS_ARM:
                    // Single mode holds off until conditions are met
                    if (!SINGLE_MODE || trig_sync2_q)
                    begin
                        ACQ_START_Q <= 1'b1;
                        state_q     <= ccss_pkg::CCSS_IDLE;
                    end
                ccss_pkg::CCSS_TEST:
                    if (tst_cnt_q >= 64'(TST_CYCLES) - 64'h1)
                    begin
                        value_q <= TEST_RESULT;
                        state_q <= ccss_pkg::CCSS_SEND;
                    end
                    else
                        tst_cnt_q <= tst_cnt_q + 64'h1;
                ccss_pkg::CCSS_SEND:
                    if (RSP_READY)
                    begin
                        if (idx_q == ndig)
                            state_q <= ccss_pkg::CCSS_IDLE;
                        else
                            idx_q <= idx_q + 2'h1;
                    end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mask, flag and setup registers

    // Unused mask bits 6 and 3 never store
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            mask_q <= 8'h00;
        else if (state_q == ccss_pkg::CCSS_EXEC && cmd_q.code == `CCSS_CMD_SRE_SET)
            mask_q <= cmd_q.arg & `CCSS_MASK_USED;
    end

    // Flag is volatile here; a non-volatile copy would sit outside
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            psc_flag_q <= 1'b0;
        else if (state_q == ccss_pkg::CCSS_EXEC && cmd_q.code == `CCSS_CMD_PSC_SET)
            psc_flag_q <= cmd_q.arg != 8'h00;
    end

    // Boot event decided on the first edge after reset release
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            boot_q           <= 1'b1;
            POWER_ON_EVENT_Q <= 1'b0;
        end
        else if (boot_q)
        begin
            boot_q           <= 1'b0;
            POWER_ON_EVENT_Q <= !psc_flag_q;
        end
    end

    // Setup restore, default load and error flag, all one-cycle pulses
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            SETUP_Q        <= '0;
            SETUP_LOAD_Q   <= 1'b0;
            ERR_SHOW_Q     <= 1'b0;
            DEFAULT_LOAD_Q <= 1'b0;
            COMPLETE_Q     <= `CCSS_COMPLETE_DEF;
        end
        else
        begin
            SETUP_LOAD_Q   <= 1'b0;
            ERR_SHOW_Q     <= 1'b0;
            DEFAULT_LOAD_Q <= 1'b0;
            if (state_q == ccss_pkg::CCSS_MEMR)
            begin
                if (mem_ok)
                begin
                    SETUP_Q      <= mem_rd;
                    SETUP_LOAD_Q <= 1'b1;
                end
                else
                    ERR_SHOW_Q <= 1'b1;
            end
            if (state_q == ccss_pkg::CCSS_EXEC && cmd_q.code == `CCSS_CMD_RST)
            begin
                COMPLETE_Q     <= `CCSS_COMPLETE_DEF;
                DEFAULT_LOAD_Q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_mask_unused: assert property (@(posedge CLK) disable iff (!RESETN)
        (mask_q[6] == 1'b0) && (mask_q[3] == 1'b0))
        else $error("unused mask bit set");
    chk_mask_load: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ccss_pkg::CCSS_EXEC && cmd_q.code == `CCSS_CMD_SRE_SET
        |=> mask_q == ($past(cmd_q.arg) & 8'hb7))
        else $error("mask not loaded");
    chk_srq_form: assert property (@(posedge CLK) disable iff (!RESETN)
        SRQ == |({COND.status_group_summary, 1'b0, COND.esb, COND.mav, 1'b0, COND.message_shown_flag,
                  COND.user, COND.trig} & mask_q))
        else $error("summary wrong");
    chk_recall_empty: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ccss_pkg::CCSS_MEMR && !mem_ok
        |=> ERR_SHOW_Q && !SETUP_LOAD_Q && $stable(SETUP_Q))
        else $error("empty recall changed setup");
    chk_recall_full: assert property (@(posedge CLK) disable iff (!RESETN)
        state_q == ccss_pkg::CCSS_MEMR && mem_ok
        |=> SETUP_LOAD_Q && SETUP_Q == $past(mem_rd))
        else $error("recall did not restore");
    chk_reset_default: assert property (@(posedge CLK) disable iff (!RESETN)
        DEFAULT_LOAD_Q |-> COMPLETE_Q == 7'h5a)
        else $error("completion default wrong");
    chk_single_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        ACQ_START_Q |-> !$past(SINGLE_MODE) || $past(trig_sync2_q))
        else $error("acquired before trigger met");
    chk_nl_end: assert property (@(posedge CLK) disable iff (!RESETN)
        RSP_VALID && RSP_Q.last |-> RSP_Q.data == 8'h0a)
        else $error("answer not newline terminated");
endmodule : ccss_top
